// [hdl/ish_handler.v]
/*
 Idle / immediate idle / geometry / queued non-data command handler.
 Assumes the host presents a decoded command block with a one-cycle
 cmd_valid strobe, synchronous to clk, and only while drive_occupied is low.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ish_consts.vh"

// Summary of operation
// (R1) Idle opcode enters idle, loads standby countdown from count, starts it.
// (R2) Entering idle spins up only when the spindle is stopped.
// (R3) In idle the spindle keeps turning and commands complete without delay.
// (R4) Period zero disables automatic power-down; nonzero enables it.
// (R5) Codes 1-240 give code times 5 s; 241-251 give (code-240) half hours.
// (R6) Code 253 gives a vendor interval between eight and twelve hours.
// (R7) Code 252 is 21 min, 255 is 21 min 15 s, 254 aborts.
// (R8) On countdown expiry without host access the drive enters standby.
// (R9) Any host access before expiry reloads the full interval.
// (R10) Immediate idle opcode enters idle, spinning up only when stopped.
// (R11) Immediate idle leaves the programmed interval untouched and restarts the countdown from it.
// (R12) Immediate idle ignores feature, count and address.
// (R13) Errors set abort in error bit 2 and status error bit 0; status fault 5 and sense 1 stay clear.
// (R14) Geometry command stores sectors per track and heads minus one.
// (R15) Geometry holds until next geometry command or soft reset reverting.
// (R16) Sectors per track of zero means zero, not 256.
// (R17) Heads minus one is the low four bits, range 0 to 15.
// (R18) Host keeps cylinder count within limit; not checked here.
// (R19) Queued non-data decodes subcommand and answers per subcommand.
// (R20) Host sets device bit 6 and clears bit 4 for queued non-data.
// (R21) Subcommand feature 3:0, data 7:4; tag count 7:3, urgency 15:14.
module ish_handler #(
    parameter SPIN_CYC = `ISH_SPINUP_CYC,
    parameter TICKS = `ISH_TICKS_PER_SEC
) (
    input wire clk,
    input wire rst,
    input wire cmd_valid,
    input wire [7:0] cmd_code,
    input wire [15:0] cmd_feature,
    input wire [15:0] cmd_count,
    input wire [47:0] cmd_lba,
    input wire [7:0] cmd_device,
    input wire host_access,
    input wire soft_reset,
    input wire keep_settings,
    input wire ncq_enabled,
    output reg [7:0] error_flags,
    output reg [7:0] status_flags,
    output reg cmd_done,
    output reg drive_occupied_flag,
    output reg idle_mode,
    output reg standby_mode,
    output reg spindle_on,
    output reg [7:0] cur_spt,
    output reg [3:0] cur_heads_m1,
    output reg [3:0] ncq_subcmd,
    output reg [3:0] ncq_subdata,
    output reg [4:0] ncq_tag,
    output reg [1:0] queue_urgency_field
);
    // ----------------------------------------
    // States
    // ----------------------------------------
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_SPIN = 4'b0010;
    localparam [3:0] ST_DONE = 4'b0100;
    localparam [3:0] ST_FAIL = 4'b1000;

    reg [3:0] state_r;
    reg [3:0] state_nxt;
    reg tmr_load;
    reg [16:0] tmr_secs;
    reg spin_start;
    reg spin_stop;
    reg cmd_abort;
    reg enter_idle;
    reg geom_load;
    reg ncq_load;
    wire spinning;
    wire spinning_up;
    wire expired;

    wire is_idle = (cmd_code == `ISH_OP_IDLE_A) || (cmd_code == `ISH_OP_IDLE_B);
    wire is_imm = (cmd_code == `ISH_OP_IMM_A) || (cmd_code == `ISH_OP_IMM_B);
    wire [7:0] period = cmd_count[`ISH_PER_MSB:0];
    wire [3:0] sub_code = cmd_feature[`ISH_SUB_MSB:`ISH_SUB_LSB];
    wire sub_known = (sub_code == `ISH_SUB_ABORT_Q) || (sub_code == `ISH_SUB_DEADLINE);
    wire dev_ok = cmd_device[`ISH_DEV_LBA_BIT] && !cmd_device[`ISH_DEV_RSV_BIT];

    // ----------------------------------------
    // Period decode
    // ----------------------------------------
    // Interval in seconds; zero means the automatic power-down is off
    function [16:0] period_secs;
        input [7:0] code;
        begin
            if (code == `ISH_PER_OFF)
                period_secs = 17'h00000; // [R4]
            else if (code <= `ISH_PER_SEC_MAX)
                period_secs = code * `ISH_SEC_PER_CODE; // [R5]
            else if (code <= `ISH_PER_HALF_MAX)
                period_secs = (code - `ISH_PER_SEC_MAX) * `ISH_SEC_PER_HALF; // [R5]
            else if (code == `ISH_PER_21M)
                period_secs = `ISH_SEC_21M; // [R7]
            else if (code == `ISH_PER_VENDOR)
                period_secs = `ISH_SEC_VENDOR; // [R6]
            else if (code == `ISH_PER_21M15)
                period_secs = `ISH_SEC_21M15; // [R7]
            else
                period_secs = 17'h00000;
        end
    endfunction

    // ----------------------------------------
    // Command decode
    // ----------------------------------------
    always @* begin
        state_nxt = state_r;
        tmr_load = 1'b0;
        tmr_secs = 17'h00000;
        spin_start = 1'b0;
        spin_stop = 1'b0;
        cmd_abort = 1'b0;
        enter_idle = 1'b0;
        geom_load = 1'b0;
        ncq_load = 1'b0;
        case (state_r)
            ST_IDLE: begin
                if (cmd_valid) begin
                    if (is_idle) begin
                        if (period == `ISH_PER_ABORT) begin
                            state_nxt = ST_FAIL; // [R7]
                        end else begin
                            enter_idle = 1'b1; // [R1]
                            tmr_load = 1'b1; // [R1]
                            tmr_secs = period_secs(period);
                            spin_start = !spinning; // [R2]
                            state_nxt = spinning ? ST_DONE : ST_SPIN; // [R3]
                        end
                    end else if (is_imm) begin
                        // Feature, count and address not looked at [R12]
                        enter_idle = 1'b1; // [R10] [R11]
                        spin_start = !spinning; // [R10]
                        state_nxt = spinning ? ST_DONE : ST_SPIN;
                    end else if (cmd_code == `ISH_OP_GEOM) begin
                        geom_load = 1'b1; // [R14]
                        state_nxt = ST_DONE;
                    end else if (cmd_code == `ISH_OP_NCQ_ND) begin
                        ncq_load = 1'b1; // [R19]
                        if (ncq_enabled && sub_known && dev_ok) // [R20]
                            state_nxt = ST_DONE; // [R19]
                        else
                            state_nxt = ST_FAIL; // [R19]
                    end else begin
                        state_nxt = ST_FAIL;
                    end
                end else if (expired && idle_mode) begin
                    spin_stop = 1'b1; // [R8]
                end
            end
            ST_SPIN: begin
                if (spinning)
                    state_nxt = ST_DONE;
            end
            ST_DONE: begin
                state_nxt = ST_IDLE;
            end
            ST_FAIL: begin
                cmd_abort = 1'b1;
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= ST_IDLE;
            error_flags <= 8'h00;
            status_flags <= 8'h00;
            cmd_done <= 1'b0;
            drive_occupied_flag <= 1'b0;
            idle_mode <= 1'b0;
            standby_mode <= 1'b1;
            spindle_on <= 1'b0;
            cur_spt <= `ISH_SPT_RESET;
            cur_heads_m1 <= `ISH_HEAD_RESET;
            ncq_subcmd <= 4'h0;
            ncq_subdata <= 4'h0;
            ncq_tag <= 5'h00;
            queue_urgency_field <= 2'h0;
        end else begin
            state_r <= state_nxt;
            cmd_done <= 1'b0;
            spindle_on <= spinning;
            drive_occupied_flag <= (state_nxt != ST_IDLE);
            status_flags[`ISH_ST_BUSY_BIT] <= (state_nxt != ST_IDLE);
            status_flags[`ISH_ST_READY_BIT] <= 1'b1;
            if (enter_idle) begin
                idle_mode <= 1'b1;
                standby_mode <= 1'b0;
            end else if (spin_stop) begin
                idle_mode <= 1'b0;
                standby_mode <= 1'b1; // [R8]
            end
            if (cmd_valid) begin
                error_flags <= 8'h00;
                status_flags[`ISH_ST_ERROR_BIT] <= 1'b0;
                status_flags[`ISH_ST_SENSE_BIT] <= 1'b0;
                status_flags[`ISH_ST_FAULT_BIT] <= 1'b0;
            end
            if (state_r == ST_DONE)
                cmd_done <= 1'b1;
            if (cmd_abort) begin
                cmd_done <= 1'b1;
                error_flags[`ISH_ERR_ABORT_BIT] <= 1'b1; // [R13]
                status_flags[`ISH_ST_ERROR_BIT] <= 1'b1; // [R13]
            end
            // New command wins over a reverting soft reset in the same cycle
            if (geom_load) begin
                cur_spt <= cmd_count[`ISH_SPT_MSB:0]; // [R14] [R16]
                cur_heads_m1 <= cmd_device[`ISH_HEAD_MSB:0]; // [R17]
            end else if (soft_reset && !keep_settings) begin
                cur_spt <= `ISH_SPT_RESET; // [R15]
                cur_heads_m1 <= `ISH_HEAD_RESET; // [R15]
            end
            if (ncq_load) begin
                ncq_subcmd <= sub_code; // [R21]
                ncq_subdata <= cmd_feature[`ISH_SUBD_MSB:`ISH_SUBD_LSB]; // [R21]
                ncq_tag <= cmd_count[`ISH_TAG_MSB:`ISH_TAG_LSB]; // [R21]
                queue_urgency_field <= cmd_count[`ISH_PRI_MSB:`ISH_PRI_LSB]; // [R21]
            end
        end
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    ish_sec_timer #(
        .TICKS(TICKS)
    ) u_timer (
        .clk(clk),
        .rst(rst),
        .load(tmr_load),
        .load_secs(tmr_secs),
        .restart(host_access || (cmd_valid && !tmr_load)), // [R9]
        .hold(!idle_mode),
        .expired(expired)
    );

    ish_spin_ctl #(
        .SPIN_CYC(SPIN_CYC)
    ) u_spin (
        .clk(clk),
        .rst(rst),
        .start(spin_start),
        .stop(spin_stop),
        .spinning(spinning),
        .spinning_up(spinning_up)
    );
endmodule
`default_nettype wire

// [hdl/ish_consts.vh]
/*
 Constants for the idle / standby command handler: opcodes, field
 positions, flag bits, period codes and timing figures.
 Assumes a 20 MHz clock; included by bare name with the guard below.
*/
`ifndef ISH_CONSTS_VH
`define ISH_CONSTS_VH

`define ISH_OP_IDLE_A 8'hE3
`define ISH_OP_IDLE_B 8'h97
`define ISH_OP_IMM_A 8'hE1
`define ISH_OP_IMM_B 8'h95
`define ISH_OP_GEOM 8'h91
`define ISH_OP_NCQ_ND 8'h63

`define ISH_ERR_ABORT_BIT 2
`define ISH_ST_FAULT_BIT 5
`define ISH_ST_SENSE_BIT 1
`define ISH_ST_ERROR_BIT 0
`define ISH_ST_READY_BIT 6
`define ISH_ST_BUSY_BIT 7

`define ISH_PER_OFF 8'h00
`define ISH_PER_SEC_MAX 8'hF0
`define ISH_PER_HALF_MAX 8'hFB
`define ISH_PER_21M 8'hFC
`define ISH_PER_VENDOR 8'hFD
`define ISH_PER_ABORT 8'hFE
`define ISH_PER_21M15 8'hFF

`define ISH_SEC_PER_CODE 17'd5
`define ISH_SEC_PER_HALF 17'd1800
`define ISH_SEC_21M 17'd1260
`define ISH_SEC_21M15 17'd1275
`define ISH_SEC_VENDOR 17'd36000

`define ISH_CLK_HZ 20000000
`define ISH_TICKS_PER_SEC `ISH_CLK_HZ
`define ISH_SPINUP_MS 100
`define ISH_SPINUP_CYC ((`ISH_CLK_HZ / 1000) * `ISH_SPINUP_MS)

`define ISH_SPT_RESET 8'h00
`define ISH_HEAD_RESET 4'h0
`define ISH_PER_MSB 7
`define ISH_SPT_MSB 7
`define ISH_HEAD_MSB 3
`define ISH_SUB_LSB 0
`define ISH_SUB_MSB 3
`define ISH_SUBD_LSB 4
`define ISH_SUBD_MSB 7
`define ISH_TAG_LSB 3
`define ISH_TAG_MSB 7
`define ISH_PRI_LSB 14
`define ISH_PRI_MSB 15
`define ISH_SUB_ABORT_Q 4'h0
`define ISH_SUB_DEADLINE 4'h1
`define ISH_DEV_LBA_BIT 6
`define ISH_DEV_RSV_BIT 4

`endif

// [hdl/ish_sec_timer.v]
/*
 Standby countdown in whole seconds with a prescaler.
 Assumes load and restart are single-cycle pulses from the main handler.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ish_consts.vh"

module ish_sec_timer #(
    parameter TICKS = `ISH_TICKS_PER_SEC
) (
    input wire clk,
    input wire rst,
    input wire load,
    input wire [16:0] load_secs,
    input wire restart,
    input wire hold,
    output reg expired
);
    reg [24:0] pre_r;
    reg [16:0] secs_r;
    reg [16:0] reload_r;
    localparam [31:0] PRE_TOP_W = TICKS - 1;
    localparam [24:0] PRE_TOP = PRE_TOP_W[24:0];

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pre_r <= 25'h0000000;
            secs_r <= 17'h00000;
            reload_r <= 17'h00000;
            expired <= 1'b0;
        end else begin
            expired <= 1'b0;
            if (load) begin
                reload_r <= load_secs;
                secs_r <= load_secs;
                pre_r <= 25'h0000000;
            end else if (restart) begin
                secs_r <= reload_r;
                pre_r <= 25'h0000000;
            end else if (!hold && secs_r != 17'h00000) begin
                if (pre_r == PRE_TOP) begin
                    pre_r <= 25'h0000000;
                    secs_r <= secs_r - 17'h00001;
                    if (secs_r == 17'h00001)
                        expired <= 1'b1;
                end else begin
                    pre_r <= pre_r + 25'h0000001;
                end
            end
        end
    end
endmodule
`default_nettype wire

// [hdl/ish_spin_ctl.v]
/*
 Spindle spin-up sequencer: a start pulse while stopped runs a fixed
 spin-up delay; a stop pulse parks the spindle.
 Assumes the main handler issues start and stop as one-cycle pulses.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ish_consts.vh"

module ish_spin_ctl #(
    parameter SPIN_CYC = `ISH_SPINUP_CYC
) (
    input wire clk,
    input wire rst,
    input wire start,
    input wire stop,
    output reg spinning,
    output reg spinning_up
);
    reg [23:0] cnt_r;
    localparam [31:0] CNT_TOP_W = SPIN_CYC - 1;
    localparam [23:0] CNT_TOP = CNT_TOP_W[23:0];

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= 24'h000000;
            spinning <= 1'b0;
            spinning_up <= 1'b0;
        end else if (stop) begin
            spinning <= 1'b0;
            spinning_up <= 1'b0;
            cnt_r <= 24'h000000;
        end else if (start && !spinning && !spinning_up) begin
            spinning_up <= 1'b1;
            cnt_r <= 24'h000000;
        end else if (spinning_up) begin
            if (cnt_r == CNT_TOP) begin
                spinning_up <= 1'b0;
                spinning <= 1'b1;
            end else begin
                cnt_r <= cnt_r + 24'h000001;
            end
        end
    end
endmodule
`default_nettype wire

// [verif/ish_chk.sv]
/*
 Port checker for the idle / standby command handler.
 Assumes one clock domain with async reset rst; bound onto ish_handler.
*/
`timescale 1ns/1ps
`default_nettype none
module ish_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_feature,
    input wire logic [15:0] cmd_count,
    input wire logic [7:0] cmd_device,
    input wire logic soft_reset,
    input wire logic ncq_enabled,
    input wire logic [7:0] error_flags,
    input wire logic [7:0] status_flags,
    input wire logic cmd_done,
    input wire logic drive_occupied_flag,
    input wire logic idle_mode,
    input wire logic standby_mode,
    input wire logic spindle_on,
    input wire logic [7:0] cur_spt,
    input wire logic [3:0] cur_heads_m1,
    input wire logic [4:0] ncq_tag
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    wire take = cmd_valid && !drive_occupied_flag;
    wire idle_cnt = cmd_code == 8'hE3 || cmd_code == 8'h97;
    wire idle_ok = (idle_cnt && cmd_count[7:0] != 8'hFE) || cmd_code == 8'hE1
        || cmd_code == 8'h95;
    wire ncq_ok = ncq_enabled && cmd_device[6] && !cmd_device[4] && cmd_feature[3:1] == 3'h0;
    wire ncq = take && cmd_code == 8'h63;

    idle_enter_a: assert property (take && idle_ok |=> idle_mode && !standby_mode)
        else $error("idle mode not entered");
    idle_fast_a: assert property (take && idle_ok && spindle_on && !standby_mode
        |=> ##1 cmd_done)
        else $error("spinning idle not done in two cycles");
    idle_spin_a: assert property (idle_mode && !drive_occupied_flag |-> spindle_on)
        else $error("idle without spindle");
    period_abort_a: assert property (take && idle_cnt && cmd_count[7:0] == 8'hFE |=> ##1
        cmd_done && error_flags[2] && status_flags[0] && idle_mode == $past(idle_mode, 2))
        else $error("period 254 not aborted");
    geom_store_a: assert property (take && cmd_code == 8'h91 |=> ##1 cmd_done
        && cur_spt == $past(cmd_count[7:0], 2) && cur_heads_m1 == $past(cmd_device[3:0], 2))
        else $error("geometry not stored");
    geom_hold_a: assert property ($changed({cur_spt, cur_heads_m1}) |->
        $past(take && cmd_code == 8'h91) || $past(soft_reset) || $past(soft_reset, 2)
        || $past(soft_reset, 3))
        else $error("geometry changed without cause");
    ncq_good_a: assert property (ncq && ncq_ok |=> ##1 cmd_done && !error_flags[2]
        && ncq_tag == $past(cmd_count[7:3], 2))
        else $error("queued command not accepted");
    ncq_bad_a: assert property (ncq && !ncq_ok |=> ##1 cmd_done && error_flags[2]
        && status_flags[0])
        else $error("queued command not aborted");
    standby_exit_a: assert property ($rose(standby_mode) |-> !idle_mode)
        else $error("standby while idle");
endmodule
bind ish_handler ish_chk i_chk (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_feature(cmd_feature), .cmd_count(cmd_count),
    .cmd_device(cmd_device), .soft_reset(soft_reset), .ncq_enabled(ncq_enabled),
    .error_flags(error_flags), .status_flags(status_flags), .cmd_done(cmd_done),
    .drive_occupied_flag(drive_occupied_flag), .idle_mode(idle_mode),
    .standby_mode(standby_mode), .spindle_on(spindle_on), .cur_spt(cur_spt),
    .cur_heads_m1(cur_heads_m1), .ncq_tag(ncq_tag));
`default_nettype wire

// [verif/ish_host_model.sv]
/*
 Host controller model: issues command blocks and access pulses.
 Assumes the handler takes a block on a clk edge with busy low.
*/
`timescale 1ns/1ps
`default_nettype none
module ish_host_model (
    input wire logic clk,
    input wire logic cmd_done,
    output logic cmd_valid,
    output logic [7:0] cmd_code,
    output logic [15:0] cmd_feature,
    output logic [15:0] cmd_count,
    output logic [47:0] cmd_lba,
    output logic [7:0] cmd_device,
    output logic host_access
);
    int slow = 0;
    int got = 0;
    // Edge at which the handler last saw a host access
    time t_acc = 0;
    initial begin
        cmd_valid = 1'b0;
        host_access = 1'b0;
        {cmd_code, cmd_feature, cmd_count, cmd_lba, cmd_device} = '0;
    end
    task automatic send(input logic [7:0] code, input logic [15:0] feat,
                        input logic [15:0] cnt, input logic [7:0] dev);
        int n;
        repeat (slow + 1) @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_code <= code;
        cmd_feature <= feat;
        cmd_count <= cnt;
        cmd_lba <= {16'($urandom), 32'($urandom)};
        cmd_device <= dev; // heads minus one in 3:0
        @(posedge clk);
        t_acc = $time;
        // Released fields flip so a stale value is never mistaken for a live one
        cmd_valid <= 1'b0;
        {cmd_code, cmd_feature, cmd_count, cmd_device} <= ~{code, feat, cnt, dev};
        n = 0;
        got = 0;
        while (got == 0 && n < 1000) begin
            @(posedge clk);
            got = (cmd_done === 1'b1);
            n++;
        end
    endtask
    task automatic poke();
        @(posedge clk);
        host_access <= 1'b1;
        @(posedge clk);
        t_acc = $time;
        host_access <= 1'b0;
    endtask
endmodule
`default_nettype wire

// [verif/testbench.sv]
/*
 Self-checking bench for the idle / standby command handler.
 Assumes shortened counts: SPIN_CYC 10, TICKS 20 cycles per second.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int TICKS = 20;
    localparam int VENDOR_SECS = 36000;
    logic clk, rst, soft_reset, keep_settings, ncq_enabled;
    wire cmd_valid, host_access, cmd_done, drive_occupied_flag;
    wire idle_mode, standby_mode, spindle_on;
    wire [7:0] cmd_code, cmd_device, error_flags, status_flags, cur_spt;
    wire [15:0] cmd_feature, cmd_count;
    wire [47:0] cmd_lba;
    wire [3:0] cur_heads_m1, ncq_subcmd, ncq_subdata;
    wire [4:0] ncq_tag;
    wire [1:0] queue_urgency_field;
    int n_mismatch = 0;
    int checked = 0;
    logic [15:0] f, c;
    logic [7:0] d;

    ish_handler #(.SPIN_CYC(10), .TICKS(TICKS)) i_dut (.clk(clk), .rst(rst),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_feature(cmd_feature),
        .cmd_count(cmd_count), .cmd_lba(cmd_lba), .cmd_device(cmd_device),
        .host_access(host_access), .soft_reset(soft_reset), .keep_settings(keep_settings),
        .ncq_enabled(ncq_enabled), .error_flags(error_flags), .status_flags(status_flags),
        .cmd_done(cmd_done), .drive_occupied_flag(drive_occupied_flag),
        .idle_mode(idle_mode), .standby_mode(standby_mode), .spindle_on(spindle_on),
        .cur_spt(cur_spt), .cur_heads_m1(cur_heads_m1), .ncq_subcmd(ncq_subcmd),
        .ncq_subdata(ncq_subdata), .ncq_tag(ncq_tag),
        .queue_urgency_field(queue_urgency_field));
    ish_host_model i_host (.clk(clk), .cmd_done(cmd_done), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_feature(cmd_feature), .cmd_count(cmd_count),
        .cmd_lba(cmd_lba), .cmd_device(cmd_device), .host_access(host_access));

    // --------------------------------------------------------------
    // Reference model and helpers
    // --------------------------------------------------------------
    function automatic int period_secs(input int code);
        if (code == 0) return 0;
        if (code <= 240) return code * 5;
        if (code <= 251) return (code - 240) * 1800;
        if (code == 252) return 1260;
        if (code == 253) return VENDOR_SECS;
        return 1275;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("mismatches=%0d checks=%0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic cmd(input logic [7:0] op, input logic [15:0] ft, input logic [15:0] ct,
                       input logic [7:0] dv);
        i_host.slow = $urandom_range(3);
        i_host.send(op, ft, ct, dv);
        check(i_host.got, 1);
        check({drive_occupied_flag, status_flags[7:5], status_flags[1]}, 5'h04);
    endtask
    task automatic timer_run(input int code, input int acc, input bit imm);
        int n;
        int exp;
        exp = period_secs(code) * TICKS;
        cmd(8'hE3, 16'($urandom), {8'($urandom), 8'(code)}, 8'h40);
        check({idle_mode, spindle_on}, 2'h3);
        if (imm) begin
            repeat (20) @(posedge clk);
            cmd(8'hE1, 16'($urandom), 16'($urandom), 8'h40);
            check(idle_mode, 1'b1);
        end
        if (acc > 0) begin
            repeat (acc) @(posedge clk);
            i_host.poke();
        end
        n = 0;
        while (standby_mode !== 1'b1 && n < exp + 300) begin
            @(posedge clk);
            n++;
        end
        // Interval runs from the last access edge, spin-up time included
        n = int'(($time - i_host.t_acc) / 50);
        check({standby_mode, idle_mode}, (exp == 0) ? 2'b01 : 2'b10);
        if (exp > 0) check(n >= exp - 8 && n <= exp + 8, 1'b1);
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (70000) @(posedge clk);
        n_mismatch++;
        give_verdict();
    end
    initial begin
        rst = 1'b1;
        soft_reset = 1'b0;
        keep_settings = 1'b1;
        ncq_enabled = 1'b1;
        void'($urandom(32'hBCC2));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        timer_run(1, 0, 0);
        timer_run(2, 60, 0);
        timer_run(1, 0, 1);
        timer_run(252, 0, 0);
        timer_run(255, 0, 0);
        timer_run(0, 0, 0);
        cmd(8'h97, 16'h0000, 16'h00FE, 8'h40);
        check({error_flags[2], status_flags[0], idle_mode}, 3'h7);
        for (int i = 0; i < 4; i++) begin
            c = (i == 0) ? 16'h0000 : 16'($urandom);
            d = 8'($urandom);
            cmd(8'h91, 16'($urandom), c, d); // no cylinder math in the block
            check({error_flags[2], cur_spt, cur_heads_m1}, {1'b0, c[7:0], d[3:0]});
        end
        for (int k = 1; k >= 0; k--) begin
            keep_settings <= k[0];
            soft_reset <= 1'b1;
            @(posedge clk);
            soft_reset <= 1'b0;
            repeat (4) @(posedge clk);
            check({cur_spt, cur_heads_m1}, k ? {c[7:0], d[3:0]} : 12'h000);
        end
        for (int i = 0; i < 5; i++) begin
            f = 16'($urandom);
            c = 16'($urandom);
            f[3:0] = (i == 2) ? 4'h2 : 4'(i & 1);
            ncq_enabled <= (i != 4);
            cmd(8'h63, f, c, (i == 3) ? 8'h50 : 8'h40);
            check(error_flags[2], i > 1);
            if (i < 2) check({ncq_subcmd, ncq_subdata, ncq_tag, queue_urgency_field},
                {f[3:0], f[7:4], c[7:3], c[15:14]});
        end
        give_verdict();
    end
endmodule
`default_nettype wire
